/* rtl/tiwl_pkg.sv */
// package: register map, field positions, reset values and timing for the irq/wake block
package tiwl_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_DROOP_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC_FLAGS = 8'h04;
  localparam logic [7:0] OFS_SRC_ENABLES = 8'h08;
  localparam logic [7:0] OFS_GROUP = 8'h0c;
  localparam logic [7:0] OFS_CPU_CTRL = 8'h10;
  localparam logic [7:0] OFS_SRC_SET = 8'h14;
  // droop control field positions
  localparam int POS_LOW_SUPPLY = 5;
  localparam int POS_DETECTOR_ON = 4;
  localparam int POS_TRIP_MSB = 2;
  // source flag / enable bit positions
  localparam int POS_TM0_A = 0;
  localparam int POS_TM0_P = 1;
  localparam int POS_TM1_A = 2;
  localparam int POS_TM1_P = 3;
  localparam int POS_DROOP = 4;
  localparam int NUM_SRC = 5;
  // group register: enables in bits 1:0, flags in bits 9:8
  localparam int NUM_GRP = 2;
  localparam int POS_GRP_FLAG = 8;
  // cpu control register bits
  localparam int POS_GIE = 0;
  localparam int POS_STACK_FULL = 1;
  localparam int POS_SLEEPING = 2;
  localparam int POS_DEEP = 3;
  // reset values
  localparam logic [7:0] RST_DROOP_CTRL = 8'h00;
  localparam logic [4:0] RST_SRC = 5'h00;
  // droop flag delay in ns, cycle count derived at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int FLAG_DELAY_NS = 20000;
  localparam int FLAG_DELAY_CYC = (FLAG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tiwl_pkg

/* rtl/tiwl_top.sv */
// top: timer/droop interrupt grouping, wake-up and supply droop detector control
// Notes on behaviour
// - each timer: A and P sources, flag, enable
// - matches set flags, routed only via groups
// - vector needs global, source, group enables, stack
// - service clears global enable, group flag only
// - any rising request flag wakes sleep/idle
// - only time-base zero wakes deep sleep
// - wake-up ignores every enable bit
// - flags stay set until serviced or cleared
// - only program counter pushed on entry
// - interrupt return sets global enable; plain keeps
// - three-bit trip level select, 1.9V to 3.6V
// - bit 5 reads low supply status
// - bit 4 switches detector on
// - bits 7, 6, 3 read zero
// - detector stays on in low-power modes
// - status may toggle near threshold
// - droop flag set after fixed delay
// - droop flag never wakes deep sleep
// - group flag set by any member source; code sets it on a member rise only with an enabled member flagged
// - droop vectored only with all enables
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module tiwl_top #(
  parameter int FLAG_DELAY = tiwl_pkg::FLAG_DELAY_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // axi4-lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  // axi4-lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  // axi4-lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // timer comparator matches, one-cycle pulses
  input wire logic i_tm0_match_a,
  input wire logic i_tm0_match_p,
  input wire logic i_tm1_match_a,
  input wire logic i_tm1_match_p,
  // time-base zero wake request, deep sleep capable
  input wire logic i_tb0_wake,
  // core handshake
  input wire logic i_vector_taken,
  input wire logic i_return_from_interrupt,
  input wire logic i_subroutine_return,
  // analog detector
  input wire logic i_low_supply_async,
  output logic o_droop_detector_on,
  output logic [2:0] o_trip_level_select,
  // to core
  output logic [1:0] o_vector_req,
  output logic o_wake
);

  // ---------------- register state
  logic detector_on_reg;
  logic [2:0] trip_reg;
  logic [4:0] src_flag_reg;
  logic [4:0] src_en_reg;
  logic [1:0] grp_en_reg;
  logic [1:0] grp_flag_reg;
  logic gie_reg;
  logic stack_full_reg;
  logic sleep_reg;
  logic deep_reg;
  logic [4:0] src_flag_prev_reg;
  logic sync1_reg;
  logic sync2_reg;
  // time-base zero request comes from the slow oscillator domain
  logic tb0_sync1_reg;
  logic tb0_sync2_reg;
  logic [15:0] delay_cnt_reg;
  logic delay_armed_reg;
  logic [1:0] vec_reg;
  logic wake_reg;

  // ---------------- axi write path
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  // readies kept as flops of their own so the ports come straight from a register
  logic awready_reg;
  logic wready_reg;

  wire aw_fire = i_awvalid & o_awready;
  wire w_fire = i_wvalid & o_wready;
  wire wr_go = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire [5:0] wr_word = aw_addr_reg[7:2];
  wire wr_droop = wr_go & (wr_word == tiwl_pkg::OFS_DROOP_CTRL[7:2]) & w_strb_reg[0];
  wire wr_flags = wr_go & (wr_word == tiwl_pkg::OFS_SRC_FLAGS[7:2]) & w_strb_reg[0];
  wire wr_enab = wr_go & (wr_word == tiwl_pkg::OFS_SRC_ENABLES[7:2]) & w_strb_reg[0];
  wire wr_grp_en = wr_go & (wr_word == tiwl_pkg::OFS_GROUP[7:2]) & w_strb_reg[0];
  wire wr_grp_fl = wr_go & (wr_word == tiwl_pkg::OFS_GROUP[7:2]) & w_strb_reg[1];
  wire wr_cpu = wr_go & (wr_word == tiwl_pkg::OFS_CPU_CTRL[7:2]) & w_strb_reg[0];
  wire wr_set = wr_go & (wr_word == tiwl_pkg::OFS_SRC_SET[7:2]) & w_strb_reg[0];
  wire wr_mapped = (aw_addr_reg[1:0] == 2'h0) & (wr_word <= tiwl_pkg::OFS_SRC_SET[7:2]);

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
        aw_addr_reg <= i_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? tiwl_pkg::RESP_OKAY : tiwl_pkg::RESP_SLVERR;
      end else if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // ---------------- axi read path
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic arready_reg;
  wire [5:0] rd_word = i_araddr[7:2];
  wire [7:0] droop_view = {2'h0, sync2_reg & detector_on_reg, detector_on_reg,
                           1'b0, trip_reg};
  wire [7:0] cpu_view = {4'h0, deep_reg, sleep_reg, stack_full_reg, gie_reg};
  wire rd_ok = (i_araddr[1:0] == 2'h0) & (rd_word <= tiwl_pkg::OFS_SRC_SET[7:2]);
  wire [31:0] rd_mux =
    (rd_word == tiwl_pkg::OFS_DROOP_CTRL[7:2]) ? {24'h0, droop_view} :
    (rd_word == tiwl_pkg::OFS_SRC_FLAGS[7:2]) ? {27'h0, src_flag_reg} :
    (rd_word == tiwl_pkg::OFS_SRC_ENABLES[7:2]) ? {27'h0, src_en_reg} :
    (rd_word == tiwl_pkg::OFS_GROUP[7:2]) ? {22'h0, grp_flag_reg, 6'h0, grp_en_reg} :
    (rd_word == tiwl_pkg::OFS_CPU_CTRL[7:2]) ? {24'h0, cpu_view} : 32'h0;

  assign o_arready = arready_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end else if (i_arvalid && o_arready) begin
      rvalid_reg <= 1'b1;
      arready_reg <= 1'b0;
      rdata_reg <= rd_ok ? rd_mux : 32'h0;
      rresp_reg <= rd_ok ? tiwl_pkg::RESP_OKAY : tiwl_pkg::RESP_SLVERR;
    end else if (rvalid_reg && i_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ---------------- comparator synchroniser and delay
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      tb0_sync1_reg <= 1'b0;
      tb0_sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= i_low_supply_async;
      sync2_reg <= sync1_reg;
      tb0_sync1_reg <= i_tb0_wake;
      tb0_sync2_reg <= tb0_sync1_reg;
    end
  end

  // low status counted only while detector is on; toggling restarts the wait
  wire low_now = sync2_reg & detector_on_reg;
  wire droop_event = low_now & delay_armed_reg & (delay_cnt_reg == 16'(FLAG_DELAY - 1));

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      delay_cnt_reg <= 16'h0;
      delay_armed_reg <= 1'b0;
    end else if (!low_now) begin
      delay_cnt_reg <= 16'h0;
      delay_armed_reg <= 1'b1;
    end else if (delay_armed_reg) begin
      if (droop_event) begin
        delay_armed_reg <= 1'b0;
      end else begin
        delay_cnt_reg <= delay_cnt_reg + 16'h1;
      end
    end
  end

  // run length of synced low status, read only by the checks below
  logic [15:0] low_run_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_run_reg <= 16'h0;
    end else if (!low_now) begin
      low_run_reg <= 16'h0;
    end else if (low_run_reg != 16'hffff) begin
      low_run_reg <= low_run_reg + 16'h1;
    end
  end

  // ---------------- source flags: hardware set beats software clear
  wire [4:0] src_hw_set = {droop_event, i_tm1_match_p, i_tm1_match_a,
                           i_tm0_match_p, i_tm0_match_a};
  wire [4:0] src_sw_set = wr_set ? w_data_reg[4:0] : 5'h0;
  wire [4:0] src_flag_next = wr_flags ? (w_data_reg[4:0] | src_hw_set | src_sw_set)
                                      : (src_flag_reg | src_hw_set | src_sw_set);

  // group 0: timer 0 pair; group 1: timer 1 pair plus droop
  wire [4:0] src_req = src_flag_reg & src_en_reg;
  wire [1:0] grp_src = {src_req[4] | src_req[3] | src_req[2], src_req[1] | src_req[0]};
  wire [4:0] src_rise = src_flag_reg & ~src_flag_prev_reg;
  wire grp0_rise = src_rise[0] | src_rise[1];
  wire grp1_rise = src_rise[2] | src_rise[3] | src_rise[4];
  wire [1:0] grp_set = {grp1_rise & src_en_reg[4:2] != 3'h0 ? grp_src[1] : 1'b0,
                        grp0_rise & (src_en_reg[1:0] != 2'h0) ? grp_src[0] : 1'b0};
  wire serve0 = i_vector_taken & vec_reg[0];
  wire serve1 = i_vector_taken & vec_reg[1] & ~vec_reg[0];
  wire [1:0] grp_clr = {serve1, serve0};
  wire [1:0] grp_flag_wr = wr_grp_fl ? w_data_reg[9:8] : grp_flag_reg;
  wire [1:0] grp_flag_next = (grp_flag_wr & ~grp_clr) | grp_set;

  wire gie_next = i_vector_taken ? 1'b0 :
                  i_return_from_interrupt ? 1'b1 :
                  wr_cpu ? w_data_reg[tiwl_pkg::POS_GIE] : gie_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_flag_reg <= tiwl_pkg::RST_SRC;
      src_flag_prev_reg <= tiwl_pkg::RST_SRC;
      src_en_reg <= tiwl_pkg::RST_SRC;
      grp_en_reg <= 2'h0;
      grp_flag_reg <= 2'h0;
      gie_reg <= 1'b0;
      stack_full_reg <= 1'b0;
      sleep_reg <= 1'b0;
      deep_reg <= 1'b0;
      detector_on_reg <= 1'b0;
      trip_reg <= 3'h0;
    end else begin
      src_flag_reg <= src_flag_next;
      src_flag_prev_reg <= src_flag_reg;
      grp_flag_reg <= grp_flag_next;
      gie_reg <= gie_next;
      if (wr_enab) src_en_reg <= w_data_reg[4:0];
      if (wr_grp_en) grp_en_reg <= w_data_reg[1:0];
      if (wr_cpu) begin
        stack_full_reg <= w_data_reg[tiwl_pkg::POS_STACK_FULL];
        sleep_reg <= w_data_reg[tiwl_pkg::POS_SLEEPING];
        deep_reg <= w_data_reg[tiwl_pkg::POS_DEEP];
      end else if (wake_reg) begin
        sleep_reg <= 1'b0;
        deep_reg <= 1'b0;
      end
      if (wr_droop) begin
        detector_on_reg <= w_data_reg[tiwl_pkg::POS_DETECTOR_ON];
        trip_reg <= w_data_reg[tiwl_pkg::POS_TRIP_MSB:0];
      end
    end
  end

  // ---------------- vector request and wake
  // only the vector index goes out; the core pushes its own program counter
  wire [1:0] vec_next = (gie_reg & ~stack_full_reg & ~i_vector_taken)
                        ? (grp_flag_reg & grp_en_reg) : 2'h0;
  // any flag edge wakes sleep; deep sleep takes only time-base zero
  wire any_rise = src_rise != 5'h0;
  wire wake_next = (sleep_reg & ~deep_reg & any_rise)
                   | (deep_reg & tb0_sync2_reg);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vec_reg <= 2'h0;
      wake_reg <= 1'b0;
      o_droop_detector_on <= 1'b0;
      o_trip_level_select <= 3'h0;
    end else begin
      vec_reg <= vec_next;
      wake_reg <= wake_next;
      o_droop_detector_on <= detector_on_reg;
      o_trip_level_select <= trip_reg;
    end
  end

  assign o_vector_req = vec_reg;
  assign o_wake = wake_reg;

  // ---------------- checks
  delay_len_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    droop_event |-> low_run_reg == 16'(FLAG_DELAY - 1)) else $error("droop delay wrong");
  flag_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    src_flag_reg[0] & ~wr_flags |=> src_flag_reg[0]) else $error("flag lost");
  hw_set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_tm0_match_a |=> src_flag_reg[0]) else $error("match lost");
  wake_edge_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sleep_reg & ~deep_reg & ~wr_cpu & $rose(src_flag_reg[0]) |=> o_wake)
    else $error("no wake on rising flag");
  deep_block_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    deep_reg & ~tb0_sync2_reg |=> !o_wake) else $error("deep sleep woken");
  gie_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_vector_taken |=> !gie_reg) else $error("global enable kept");
  return_from_interrupt_set_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_return_from_interrupt & ~i_vector_taken |=> gie_reg) else $error("return_from_interrupt no enable");
  vec_gate_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!gie_reg || stack_full_reg) |=> o_vector_req == 2'h0) else $error("vector ungated");
  status_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $rose(o_rvalid) && $past(i_araddr) == tiwl_pkg::OFS_DROOP_CTRL
    |-> o_rdata[7:6] == 2'h0 && !o_rdata[3] && o_rdata[31:8] == 24'h0)
    else $error("reserved bits set");
  // servicing drops only the group flag, the source flag stays
  grp_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    serve0 & ~grp_set[0] |=> !grp_flag_reg[0]) else $error("group flag kept");
  src_keep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    serve0 & src_flag_reg[0] & ~wr_flags |=> src_flag_reg[0])
    else $error("source flag lost");
  // enables play no part in waking
  wake_noen_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sleep_reg & ~deep_reg & ~wr_cpu & (src_rise != 5'h0) & (src_en_reg == 5'h0) |=> o_wake)
    else $error("wake needs enable");
  droop_deep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    deep_reg & src_rise[4] & ~tb0_sync2_reg |=> !o_wake)
    else $error("droop woke deep sleep");
  // plain return leaves the global enable cleared
  ret_keep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_subroutine_return & ~gie_reg & ~wr_cpu & ~i_return_from_interrupt |=> !gie_reg)
    else $error("return set enable");
  // hardware match sets the flag even while software writes the register
  set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_tm1_match_p |=> src_flag_reg[3]) else $error("timer one match lost");

endmodule : tiwl_top

/* testbench/tiwl_core_model.sv */
// core model: takes pending vectors, then returns after a service delay
`timescale 1ns/1ns
module tiwl_core_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // from block
  input wire logic [1:0] i_vector_req,
  // behaviour select
  input wire logic i_slow,
  input wire logic i_use_return_from_interrupt,
  // to block
  output logic o_vector_taken,
  output logic o_return_from_interrupt,
  output logic o_ret
);
  typedef enum logic [1:0] {CM_IDLE, CM_WAIT, CM_SERVE, CM_DONE} tiwl_core_st_e;
  tiwl_core_st_e st_reg;
  logic [3:0] cnt_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= CM_IDLE;
      cnt_reg <= 4'h0;
      o_vector_taken <= 1'b0;
      o_return_from_interrupt <= 1'b0;
      o_ret <= 1'b0;
    end else begin
      o_vector_taken <= 1'b0;
      o_return_from_interrupt <= 1'b0;
      o_ret <= 1'b0;
      case (st_reg)
        CM_IDLE: if (i_vector_req != 2'h0) begin
          cnt_reg <= i_slow ? 4'h5 : 4'h1;
          st_reg <= CM_WAIT;
        end
        CM_WAIT: if (cnt_reg == 4'h0) begin
          o_vector_taken <= 1'b1;
          cnt_reg <= 4'h8;
          st_reg <= CM_SERVE;
        end else cnt_reg <= cnt_reg - 4'h1;
        CM_SERVE: if (cnt_reg == 4'h0) begin
          o_return_from_interrupt <= i_use_return_from_interrupt;
          o_ret <= !i_use_return_from_interrupt;
          st_reg <= CM_DONE;
        end else cnt_reg <= cnt_reg - 4'h1;
        default: st_reg <= CM_IDLE;
      endcase
    end
  end
endmodule : tiwl_core_model

/* testbench/timer_irq_wakeup_and_lowvolt_detect_tb.sv */
// testbench: register access, grouping, wake-up and droop flag checks
`timescale 1ns/1ns
module timer_irq_wakeup_and_lowvolt_detect_tb;
  logic i_clk = 0, i_rstn = 0;
  logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [7:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0;
  logic [3:0] m = 0;
  logic i_tb0_wake = 0, sup = 0, slow = 0, use_return_from_interrupt = 0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_on, taken, return_from_interrupt, ret, o_wake;
  logic [1:0] o_bresp, o_rresp, o_vector_req;
  logic [1:0] vseen = 0;
  logic vclr = 0;
  logic [31:0] o_rdata;
  logic [2:0] o_trip;
  int errors = 0, tests_run = 0, wakes = 0, cyc = 0, w0;
  always #50 i_clk = ~i_clk;
  tiwl_top #(.FLAG_DELAY(4)) DUT (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(4'hf),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .i_tm0_match_a(m[0]), .i_tm0_match_p(m[1]), .i_tm1_match_a(m[2]), .i_tm1_match_p(m[3]),
    .i_tb0_wake(i_tb0_wake), .i_vector_taken(taken), .i_return_from_interrupt(return_from_interrupt),
    .i_subroutine_return(ret), .i_low_supply_async(sup), .o_droop_detector_on(o_on),
    .o_trip_level_select(o_trip), .o_vector_req(o_vector_req), .o_wake(o_wake));
  tiwl_core_model core (.i_clk(i_clk), .i_rstn(i_rstn), .i_vector_req(o_vector_req),
    .i_slow(slow), .i_use_return_from_interrupt(use_return_from_interrupt), .o_vector_taken(taken), .o_return_from_interrupt(return_from_interrupt), .o_ret(ret));
  always @(posedge i_clk) begin
    cyc++;
    if (o_wake === 1'b1) wakes++;
    if (vclr) vseen <= 2'h0;
    else if (o_vector_req !== 2'h0) vseen <= vseen | o_vector_req;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    i_awvalid <= 1;
    i_awaddr <= a;
    i_wvalid <= 1;
    i_wdata <= d;
    i_bready <= 1;
    do begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 0;
      if (i_wvalid && o_wready) i_wvalid <= 0;
    end while (o_bvalid !== 1'b1);
    i_bready <= 0;
    chk(o_bresp, er);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_clk);
    i_arvalid <= 1;
    i_araddr <= a;
    i_rready <= 1;
    do begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 0;
    end while (o_rvalid !== 1'b1);
    i_rready <= 0;
    chk(o_rdata, e);
    chk(o_rresp, er);
  endtask : rd
  task hit(input logic [3:0] v);
    @(posedge i_clk) begin
      m <= v;
      vclr <= 0;
    end
    @(posedge i_clk) m <= 0;
    repeat (10) @(posedge i_clk);
  endtask : hit
  initial begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    wr(8'h40, 32'h1, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h00, 32'hff, 2'h0);
    rd(8'h00, 32'h17, 2'h0);
    for (int k = 0; k < 8; k++) begin
      wr(8'h00, 32'h10 | k, 2'h0);
      rd(8'h00, 32'h10 | k, 2'h0);
      chk({29'h0, o_trip}, k);
      chk({31'h0, o_on}, 32'h1);
    end
    $display("test registers done");
    wr(8'h10, 32'h4, 2'h0);
    w0 = wakes;
    hit(4'h1);
    chk(wakes, w0 + 1);
    rd(8'h04, 32'h1, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    wr(8'h14, 32'h1, 2'h0);
    rd(8'h04, 32'h1, 2'h0);
    wr(8'h10, 32'h4, 2'h0);
    hit(4'h1);
    chk(wakes, w0 + 1);
    $display("test wake done");
    wr(8'h08, 32'h1f, 2'h0);
    wr(8'h0c, 32'h3, 2'h0);
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      use_return_from_interrupt <= !i[0];
      wr(8'h04, 32'h0, 2'h0);
      wr(8'h10, 32'h1, 2'h0);
      vclr <= 1;
      hit(i ? 4'h8 : 4'h1);
      repeat (20) @(posedge i_clk);
      chk(vseen, i ? 2'h2 : 2'h1);
      rd(8'h0c, 32'h3, 2'h0);
      rd(8'h04, i ? 32'h8 : 32'h1, 2'h0);
      rd(8'h10, i ? 32'h0 : 32'h1, 2'h0);
    end
    wr(8'h04, 32'h0, 2'h0);
    wr(8'h10, 32'h3, 2'h0);
    vclr <= 1;
    hit(4'h4);
    chk(vseen, 2'h0);
    rd(8'h0c, 32'h203, 2'h0);
    $display("test vector done");
    wr(8'h10, 32'h0, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    wr(8'h0c, 32'h3, 2'h0);
    wr(8'h00, 32'h10, 2'h0);
    repeat (10) @(posedge i_clk);
    wr(8'h10, 32'hc, 2'h0);
    w0 = wakes;
    @(posedge i_clk) sup <= 1;
    rd(8'h04, 32'h0, 2'h0);
    repeat (30) @(posedge i_clk);
    chk(wakes, w0);
    rd(8'h00, 32'h30, 2'h0);
    rd(8'h04, 32'h10, 2'h0);
    @(posedge i_clk) i_tb0_wake <= 1;
    @(posedge i_clk) i_tb0_wake <= 0;
    repeat (5) @(posedge i_clk);
    chk(wakes, w0 + 1);
    @(posedge i_clk) sup <= 0;
    repeat (10) @(posedge i_clk);
    rd(8'h00, 32'h10, 2'h0);
    $display("test droop done");
    wrap_up();
  end
endmodule : timer_irq_wakeup_and_lowvolt_detect_tb
